//--- dv/scan_ctrl_model.sv
// behavioural scan controller that drives the test access pins
`timescale 1ns/1ps
module scan_ctrl_model (
   // system clock that paces the test clock
   input wire logic clk,
   // test access pins
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe
);
   // test clock starts low and rests high between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // one 400 ns test clock period; levels move only with the fall
   task automatic step(input logic m, input logic d, output logic q,
      output logic oe);
      @(negedge clk);
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      q = tdo; // read just before the rise that shifts it out
      oe = tdo_oe;
      tck = 1'b1;
      repeat (3) @(negedge clk);
   endtask : step
   // park the clock low; data wanders so a stale level is not trusted
   task automatic park();
      @(negedge clk);
      tck = 1'b0;
      tdi = ~tdi;
   endtask : park
endmodule : scan_ctrl_model

//--- dv/scan_tap_sva.sv
// assertion checker for the serial test access port
`timescale 1ns/1ps
module scan_tap_sva #(
   parameter int IR_LEN = 8,
   parameter int DATA_LEN = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // test access pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe,
   // functional pins and observation
   input wire logic [DATA_LEN-1:0] func_in,
   input wire logic [DATA_LEN-1:0] func_out,
   input wire logic [IR_LEN-1:0] instr,
   input scan_tap_pkg::tap_state_t tap_state
);
   import scan_tap_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // a shift entered from capture shows captured data first; one resumed
   // through exit2 goes on with bits already in the register
   logic fresh_scan;
   logic next_fresh_scan;
   always_comb begin
      next_fresh_scan = fresh_scan;
      if (tap_state inside {CAPTURE_IR, CAPTURE_DR}) begin
         next_fresh_scan = 1'b1;
      end else if (tap_state inside {EXIT2_IR, EXIT2_DR}) begin
         next_fresh_scan = 1'b0;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fresh_scan <= 1'b0;
      end else begin
         fresh_scan <= next_fresh_scan;
      end
   end
   // ----------------------------------------------------------------
   // state steps
   // ----------------------------------------------------------------
   sequence s_leave_tlr;
      tap_state == TEST_LOGIC_RESET ##1 tap_state != TEST_LOGIC_RESET;
   endsequence
   sequence s_leave_capir;
      tap_state == CAPTURE_IR ##1 tap_state != CAPTURE_IR;
   endsequence
   // pin outputs may move only while the synchronised test clock is low;
   // the pin is still low when the registered update lands
   chk_tdo_on_fall: assert property (!$stable(tdo) |-> !tck)
      else $error("tdo moved while tck high");
   chk_oe_on_fall: assert property (!$stable(tdo_oe) |-> !tck)
      else $error("tdo_oe moved while tck high");
   chk_state_on_rise: assert property (!$stable(tap_state) |-> tck)
      else $error("state moved while tck low");
   chk_oe_window: assert property (tdo_oe |-> tap_state inside
      {SHIFT_IR, SHIFT_DR, EXIT1_IR, EXIT1_DR})
      else $error("tdo driven outside a scan");
   chk_oe_off_exit: assert property ($fell(tdo_oe) |->
      tap_state inside {EXIT1_IR, EXIT1_DR})
      else $error("tdo released outside exit1");
   chk_ir_first_bit: assert property ($rose(tdo_oe) && fresh_scan &&
      tap_state == SHIFT_IR |-> tdo == IR_CAPTURE[0])
      else $error("first ir bit wrong");
   chk_bypass_zero: assert property ($rose(tdo_oe) && tap_state == SHIFT_DR
      && fresh_scan && instr == IR_BYPASS |-> !tdo)
      else $error("bypass stage not zero");
   chk_instr_update: assert property (!$stable(instr) |-> !tck &&
      tap_state inside {UPDATE_IR, TEST_LOGIC_RESET})
      else $error("instruction changed out of place");
   chk_fout_update: assert property (!$stable(func_out) |-> !tck &&
      tap_state == UPDATE_DR)
      else $error("func_out changed out of place");
   chk_tlr_exit: assert property (s_leave_tlr |->
      tap_state == RUN_TEST_IDLE)
      else $error("reset state left wrongly");
   chk_capir_exit: assert property (s_leave_capir |->
      tap_state inside {SHIFT_IR, EXIT1_IR})
      else $error("capture-ir left wrongly");
endmodule : scan_tap_sva

bind scan_tap_timing scan_tap_sva #(
   .IR_LEN(IR_LEN),
   .DATA_LEN(DATA_LEN)
) scan_tap_sva_i (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
   .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .func_in(func_in),
   .func_out(func_out), .instr(instr), .tap_state(tap_state));

//--- dv/tb.sv
// self-checking testbench for the serial test access port
`timescale 1ns/1ps
module tb;
   import scan_tap_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic tck, tms, tdi, tdo, tdo_oe, q, oe;
   logic [DATA_W-1:0] func_in = 8'h5A;
   logic [DATA_W-1:0] func_out;
   logic [IR_W-1:0] instr;
   tap_state_t tap_state;
   int fail_count = 0;
   int check_count = 0;
   always #25 clk = ~clk;
   scan_tap_timing scan_tap_timing_i (.clk(clk), .sys_rst(sys_rst),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
      .func_in(func_in), .func_out(func_out), .instr(instr),
      .tap_state(tap_state));
   scan_ctrl_model scan_ctrl_model_i (.clk(clk), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : check
   // one test clock, then let the state update land before looking
   task automatic go(input logic m, input tap_state_t s,
      input logic d = 1'b0);
      scan_ctrl_model_i.step(m, d, q, oe);
      @(posedge clk);
      #1;
      check(tap_state === s, "state step");
   endtask : go
   // shift n bits lsb first, tms high on the last; collect tdo
   task automatic shift(input logic [7:0] v, input int n, output logic [7:0] o,
      input tap_state_t s);
      tap_state_t sh;
      sh = (s == EXIT1_IR) ? SHIFT_IR : SHIFT_DR;
      o = 8'h00;
      for (int i = 0; i < n; i++) begin
         go(i == n - 1, (i == n - 1) ? s : sh, v[i]);
         o[i] = q;
         check(oe === 1'b1, "tdo not driven");
      end
   endtask : shift
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // starts and ends in select-dr so data scans can follow directly
   task automatic ir_scan(input logic [7:0] v);
      logic [7:0] o;
      go(1'b1, SELECT_IR);
      go(1'b0, CAPTURE_IR);
      go(1'b0, SHIFT_IR);
      shift(v, 8, o, EXIT1_IR);
      check(o === IR_CAPTURE, "ir capture out");
      go(1'b1, UPDATE_IR);
      check(oe === 1'b0, "tdo not floated");
      go(1'b1, SELECT_DR);
      check(instr === v, "instruction load");
   endtask : ir_scan
   task automatic dr_scan(input logic [7:0] v, input int n,
      input logic [7:0] exp, input logic [7:0] fout);
      logic [7:0] o;
      go(1'b0, CAPTURE_DR);
      go(1'b0, SHIFT_DR);
      shift(v, n, o, EXIT1_DR);
      check(o === exp, "dr out");
      go(1'b1, UPDATE_DR);
      check(oe === 1'b0, "tdo not floated");
      go(1'b1, SELECT_DR);
      check(func_out === fout, "data update");
   endtask : dr_scan
   // pause and exit2 detours on both paths; sample data moved before capture
   task automatic pause_walk();
      logic [7:0] o;
      go(1'b1, SELECT_IR);
      go(1'b0, CAPTURE_IR);
      go(1'b1, EXIT1_IR);
      go(1'b0, PAUSE_IR);
      go(1'b1, EXIT2_IR);
      go(1'b1, UPDATE_IR);
      go(1'b1, SELECT_DR);
      check(instr === IR_CAPTURE, "unshifted instruction");
      @(negedge clk);
      func_in = 8'h96;
      go(1'b0, CAPTURE_DR);
      go(1'b1, EXIT1_DR);
      go(1'b0, PAUSE_DR);
      go(1'b1, EXIT2_DR);
      check(oe === 1'b0, "tdo driven in pause");
      go(1'b0, SHIFT_DR);
      shift(8'hC3, 8, o, EXIT1_DR);
      check(o === 8'h96, "resumed dr out");
      go(1'b1, UPDATE_DR);
      go(1'b1, SELECT_DR);
      check(func_out === 8'hC3, "resumed update");
   endtask : pause_walk
   // five high mode levels from mid-scan reach reset; instr back to bypass
   task automatic five_ones();
      ir_scan(8'h3C);
      go(1'b0, CAPTURE_DR);
      go(1'b0, SHIFT_DR);
      go(1'b1, EXIT1_DR);
      go(1'b1, UPDATE_DR);
      go(1'b1, SELECT_DR);
      go(1'b1, SELECT_IR);
      go(1'b1, TEST_LOGIC_RESET);
      go(1'b0, RUN_TEST_IDLE);
      check(instr === IR_BYPASS, "reset instruction");
   endtask : five_ones
   // hang guard: the whole run is far shorter than this
   initial begin
      #2000000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
      check(instr === IR_RESET, "reset instruction");
      check(tap_state === TEST_LOGIC_RESET, "reset state");
      go(1'b1, TEST_LOGIC_RESET);
      go(1'b0, RUN_TEST_IDLE);
      go(1'b1, SELECT_DR);
      ir_scan(8'h3C);
      dr_scan(8'hA5, 8, 8'h5A, 8'hA5);
      ir_scan(IR_BYPASS);
      dr_scan(8'h05, 3, 8'h02, 8'hA5);
      pause_walk();
      five_ones();
      scan_ctrl_model_i.park();
      tally_and_finish();
   end
endmodule : tb

//--- hw/bit_sync.sv
// two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
module bit_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // level from outside the clock domain
   input wire logic [WIDTH-1:0] async_in,
   // level safe to use in the clock domain
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync_out;

   // the first stage feeds the second stage only
   always_comb begin
      next_meta = async_in;
      next_sync_out = meta;
   end

   // both stages clear to zero under reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= next_meta;
         sync_out <= next_sync_out;
      end
   end

endmodule : bit_sync

//--- hw/scan_tap_timing.sv
// serial test access port: state machine, instruction and data scan
`timescale 1ns/1ps
module scan_tap_timing #(
   parameter int IR_LEN = scan_tap_pkg::IR_W,
   parameter int DATA_LEN = scan_tap_pkg::DATA_W
) (
   // system clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // test access pins from the scan controller
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // functional pins seen by the boundary sample path
   input wire logic [DATA_LEN-1:0] func_in,
   output logic [DATA_LEN-1:0] func_out,
   // observation of the test logic
   output logic [IR_LEN-1:0] instr,
   output scan_tap_pkg::tap_state_t tap_state
);
   import scan_tap_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] pins_sync;
   logic [DATA_LEN-1:0] func_sync;
   logic tck_s;
   logic tms_s;
   logic tdi_s;

   // tck, tms and tdi share one synchroniser so they stay aligned
   bit_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in({tck, tms, tdi}),
      .sync_out(pins_sync)
   );

   bit_sync #(
      .WIDTH(DATA_LEN)
   ) u_func_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(func_in),
      .sync_out(func_sync)
   );

   assign tck_s = pins_sync[2];
   assign tms_s = pins_sync[1];
   assign tdi_s = pins_sync[0];

   // ----------------------------------------------------------------
   // test clock edge detection
   // ----------------------------------------------------------------
   logic tck_prev;
   logic next_tck_prev;
   logic tck_rise;
   logic tck_fall;

   // edges are found on the synchronised copy only; the test clock
   // must stay well below half the system rate for this to work
   always_comb begin
      next_tck_prev = tck_s;
      tck_rise = tck_s & ~tck_prev;
      tck_fall = ~tck_s & tck_prev;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tck_prev <= 1'b0;
      end else begin
         tck_prev <= next_tck_prev;
      end
   end

   // ----------------------------------------------------------------
   // state machine, advanced on rising test clock edges
   // ----------------------------------------------------------------
   tap_state_t state;
   tap_state_t next_state;
   tap_state_t step;

   // transition table keyed by the sampled tms level
   always_comb begin
      step = state;
      unique case (state)
         TEST_LOGIC_RESET: step = tms_s ? TEST_LOGIC_RESET
                                        : RUN_TEST_IDLE;
         RUN_TEST_IDLE: step = tms_s ? SELECT_DR : RUN_TEST_IDLE;
         SELECT_DR: step = tms_s ? SELECT_IR : CAPTURE_DR;
         CAPTURE_DR: step = tms_s ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR: step = tms_s ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR: step = tms_s ? UPDATE_DR : PAUSE_DR;
         PAUSE_DR: step = tms_s ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR: step = tms_s ? UPDATE_DR : SHIFT_DR;
         UPDATE_DR: step = tms_s ? SELECT_DR : RUN_TEST_IDLE;
         SELECT_IR: step = tms_s ? TEST_LOGIC_RESET : CAPTURE_IR;
         CAPTURE_IR: step = tms_s ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR: step = tms_s ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR: step = tms_s ? UPDATE_IR : PAUSE_IR;
         PAUSE_IR: step = tms_s ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR: step = tms_s ? UPDATE_IR : SHIFT_IR;
         UPDATE_IR: step = tms_s ? SELECT_DR : RUN_TEST_IDLE;
      endcase
      // tms is only looked at on a rising edge
      next_state = tck_rise ? step : state;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= TEST_LOGIC_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // shift paths, all updated on rising test clock edges
   // ----------------------------------------------------------------
   logic [IR_LEN-1:0] ir_shift;
   logic [IR_LEN-1:0] next_ir_shift;
   logic bypass_bit;
   logic next_bypass_bit;
   logic [DATA_LEN-1:0] dr_shift;
   logic [DATA_LEN-1:0] next_dr_shift;
   logic bypass_sel;

   // only the all-ones code selects bypass; every other code scans the
   // sample register on the functional pins
   assign bypass_sel = (instr == IR_BYPASS);

   // the current state decides the action of the rising edge that
   // leaves it, so capture and final shift land on the exit edge
   always_comb begin
      next_ir_shift = ir_shift;
      next_bypass_bit = bypass_bit;
      next_dr_shift = dr_shift;
      if (tck_rise) begin
         unique case (state)
            CAPTURE_IR: next_ir_shift = IR_CAPTURE;
            SHIFT_IR: begin
               // lsb first; the exit edge shifts too
               next_ir_shift = {tdi_s, ir_shift[IR_LEN-1:1]};
            end
            CAPTURE_DR: begin
               if (bypass_sel) begin
                  next_bypass_bit = BYPASS_CAPTURE;
               end else begin
                  next_dr_shift = func_sync;
               end
            end
            SHIFT_DR: begin
               if (bypass_sel) begin
                  next_bypass_bit = tdi_s;
               end else begin
                  next_dr_shift = {tdi_s, dr_shift[DATA_LEN-1:1]};
               end
            end
            default: begin
               next_ir_shift = ir_shift;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ir_shift <= IR_CAPTURE;
         bypass_bit <= BYPASS_CAPTURE;
         dr_shift <= DATA_RESET;
      end else begin
         ir_shift <= next_ir_shift;
         bypass_bit <= next_bypass_bit;
         dr_shift <= next_dr_shift;
      end
   end

   // ----------------------------------------------------------------
   // falling edge outputs: serial output, instruction, parallel data
   // ----------------------------------------------------------------
   logic next_tdo;
   logic next_tdo_oe;
   logic [IR_LEN-1:0] next_instr;
   logic [DATA_LEN-1:0] next_func_out;

   // tdo keeps its last bit while floating, which is harmless since
   // the enable is low; it only moves on a falling edge
   always_comb begin
      next_tdo = tdo;
      next_tdo_oe = tdo_oe;
      next_instr = instr;
      next_func_out = func_out;
      if (tck_fall) begin
         unique case (state)
            SHIFT_IR: begin
               next_tdo = ir_shift[0];
               next_tdo_oe = 1'b1;
            end
            SHIFT_DR: begin
               next_tdo = bypass_sel ? bypass_bit : dr_shift[0];
               next_tdo_oe = 1'b1;
            end
            UPDATE_IR: begin
               next_instr = ir_shift;
               next_tdo_oe = 1'b0;
            end
            UPDATE_DR: begin
               // bypass has no parallel stage to update
               if (!bypass_sel) begin
                  next_func_out = dr_shift;
               end
               next_tdo_oe = 1'b0;
            end
            TEST_LOGIC_RESET: begin
               next_instr = IR_RESET;
               next_tdo_oe = 1'b0;
            end
            default: begin
               // exit1 states and all others float the output
               next_tdo_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
         instr <= IR_RESET;
         func_out <= DATA_RESET;
      end else begin
         tdo <= next_tdo;
         tdo_oe <= next_tdo_oe;
         instr <= next_instr;
         func_out <= next_func_out;
      end
   end

   // ----------------------------------------------------------------
   // state observation
   // ----------------------------------------------------------------
   tap_state_t next_tap_state;

   // registered copy so the port comes straight from a flop
   always_comb begin
      next_tap_state = next_state;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tap_state <= TEST_LOGIC_RESET;
      end else begin
         tap_state <= next_tap_state;
      end
   end

endmodule : scan_tap_timing

//--- inc/scan_tap_pkg.sv
// package with the constants and types of the serial test access port
package scan_tap_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int IR_W = 8;            // instruction register length
   localparam int DATA_W = 8;          // functional pins per direction
   localparam int SYNC_STAGES = 2;     // flops ahead of any pin logic

   // ----------------------------------------------------------------
   // instruction register values
   // ----------------------------------------------------------------
   localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;  // 10000001
   localparam logic [IR_W-1:0] IR_BYPASS = 8'hFF;   // 11111111
   localparam logic [IR_W-1:0] IR_RESET = IR_BYPASS;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic BYPASS_CAPTURE = 1'b0;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

   // ----------------------------------------------------------------
   // test access state machine
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      TEST_LOGIC_RESET,
      RUN_TEST_IDLE,
      SELECT_DR,
      CAPTURE_DR,
      SHIFT_DR,
      EXIT1_DR,
      PAUSE_DR,
      EXIT2_DR,
      UPDATE_DR,
      SELECT_IR,
      CAPTURE_IR,
      SHIFT_IR,
      EXIT1_IR,
      PAUSE_IR,
      EXIT2_IR,
      UPDATE_IR
   } tap_state_t;

endpackage : scan_tap_pkg
